// ==== dv/mbcm_host.sv ====
`timescale 1ns/1ps
module mbcm_host
    import mbcm_pkg::*;
(
    input  wire logic        mclk_i,   // Controller clock.
    input  wire logic [31:0] wb_dat_i, // Read data from the block.
    input  wire logic        wb_ack_i, // Acknowledge from the block.
    output logic             wb_cyc_o, // Cycle.
    output logic             wb_stb_o, // Strobe.
    output logic             wb_we_o,  // Write enable.
    output logic [11:0]      wb_adr_o, // Byte address.
    output logic [3:0]       wb_sel_o, // Byte lanes.
    output logic [31:0]      wb_dat_o  // Write data.
);
    initial begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o  = 1'b0;
        wb_adr_o = 12'hFFF;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h0000_0000;
    end

    function automatic logic [11:0] badr(input logic [3:0] page, input int n);
        return {page, n[5:0], 2'b00};
    endfunction : badr

    // Released lines show the inverse so a stale value is never mistaken for a request.
    task automatic xfer(input logic we, input logic [11:0] adr, input logic [31:0] dat,
                        output logic [31:0] rdat);
        @(posedge mclk_i);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o  <= we;
        wb_adr_o <= adr;
        wb_sel_o <= 4'hF;
        wb_dat_o <= dat;
        @(posedge mclk_i);
        while (wb_ack_i !== 1'b1) @(posedge mclk_i);
        rdat = wb_dat_i;
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_we_o  <= ~we;
        wb_adr_o <= ~adr;
        wb_sel_o <= 4'h0;
        wb_dat_o <= ~dat;
    endtask : xfer

    task automatic wr(input logic [11:0] adr, input logic [31:0] dat);
        logic [31:0] d;
        xfer(1'b1, adr, dat, d);
    endtask : wr

    task automatic rd(input logic [11:0] adr, output logic [31:0] d);
        xfer(1'b0, adr, 32'h0000_0000, d);
    endtask : rd

    // Control bits, cycle filter, lock, frame id, unlock.
    task automatic cfg_buf(input int n, input logic [31:0] bcs, input logic [31:0] ccf,
                           input logic [31:0] fid);
        wr(badr(MBCM_PAGE_BCS, n), bcs);
        wr(badr(MBCM_PAGE_CCF, n), ccf);
        wr(badr(MBCM_PAGE_BCS, n), bcs | 32'h0000_0002);
        wr(badr(MBCM_PAGE_FID, n), fid);
        wr(badr(MBCM_PAGE_BCS, n), bcs);
    endtask : cfg_buf
endmodule : mbcm_host

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
module testbench
    import mbcm_pkg::*;
;
    logic        mclk_i;
    logic        resetn_i;
    logic        wb_cyc;
    logic        wb_stb;
    logic        wb_we;
    logic [11:0] wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_wdat;
    logic [31:0] wb_rdat;
    logic        wb_ack;
    logic        init_busy;
    logic        cfg_st;
    logic        nrm_st;
    logic [5:0]  fifo_act;
    int          fail_count;
    int          n_compared;

    mbcm_top DUT (.mclk_i(mclk_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .init_busy_o(init_busy),
        .config_state_o(cfg_st), .normal_state_o(nrm_st), .active_fifo_size_o(fifo_act));

    mbcm_host host (.mclk_i(mclk_i), .wb_dat_i(wb_rdat), .wb_ack_i(wb_ack), .wb_cyc_o(wb_cyc),
        .wb_stb_o(wb_stb), .wb_we_o(wb_we), .wb_adr_o(wb_adr), .wb_sel_o(wb_sel),
        .wb_dat_o(wb_wdat));

    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            fail_count++;
        end
    endtask : chk

    task automatic rchk(input string nm, input logic [11:0] adr, input logic [31:0] exp);
        logic [31:0] d;
        host.rd(adr, d);
        chk(nm, exp, d);
    endtask : rchk

    task automatic chk_states(input logic [31:0] c, input logic [31:0] n);
        chk("config_state", c, 32'(cfg_st));
        chk("normal_state", n, 32'(nrm_st));
    endtask : chk_states

    // Reset, then poll the signature; a write during initialization must be lost.
    task automatic do_reset();
        logic [31:0] d;
        @(posedge mclk_i);
        resetn_i <= 1'b0;
        repeat (5) @(posedge mclk_i);
        #1;
        chk("busy_in_reset", 32'h0000_0001, 32'(init_busy));
        chk("fifo_in_reset", 32'h0000_0000, 32'(fifo_act));
        chk_states(32'h0000_0000, 32'h0000_0000);
        @(posedge mclk_i);
        resetn_i <= 1'b1;
        rchk("sig_in_init", MBCM_OFS_SIG, 32'h0000_0000);
        host.wr(MBCM_OFS_FSIZE, 32'h0000_0005);
        d = 32'h0000_0000;
        for (int i = 0; i < 40 && d !== 32'(MBCM_SIG_VALUE); i++) host.rd(MBCM_OFS_SIG, d);
        chk("sig_done", 32'(MBCM_SIG_VALUE), d);
        chk("busy_done", 32'h0000_0000, 32'(init_busy));
        chk_states(32'h0000_0001, 32'h0000_0000);
        rchk("fsize_init_wr", MBCM_OFS_FSIZE, 32'h0000_0000);
        rchk("mcr_cfg", MBCM_OFS_MCR, 32'h0000_0003);
    endtask : do_reset

    task automatic t_reset_values();
        for (int n = 0; n < 60; n++) begin
            rchk("bcs_rst", host.badr(MBCM_PAGE_BCS, n), 32'h0000_0000);
            rchk("ccf_rst", host.badr(MBCM_PAGE_CCF, n), 32'h0000_0000);
            rchk("fid_rst", host.badr(MBCM_PAGE_FID, n), 32'h0000_0000);
        end
        rchk("unmapped", 12'h0FC, 32'h0000_0000);
    endtask : t_reset_values

    task automatic t_fifo_cfg();
        host.wr(MBCM_OFS_FSIZE, 32'h0000_003B);
        rchk("fsize_max", MBCM_OFS_FSIZE, 32'h0000_003B);
        host.wr(MBCM_OFS_FSIZE, 32'h0000_003C);
        rchk("fsize_over", MBCM_OFS_FSIZE, 32'h0000_003B);
        host.wr(MBCM_OFS_FSIZE, 32'h0000_0004);
        rchk("fsize_4", MBCM_OFS_FSIZE, 32'h0000_0004);
        host.wr(host.badr(MBCM_PAGE_BCS, 1), 32'h0000_0FFF);
        rchk("fifo_buf_rx", host.badr(MBCM_PAGE_BCS, 1), 32'h0000_085B);
        chk("fifo_not_yet", 32'h0000_0000, 32'(fifo_act));
    endtask : t_fifo_cfg

    task automatic t_buffers();
        host.cfg_buf(6, 32'h0000_01A8, 32'h0000_1234, 32'h0000_0055);
        rchk("dbl_host_bcs", host.badr(MBCM_PAGE_BCS, 6), 32'h0000_01A8);
        rchk("dbl_host_fid", host.badr(MBCM_PAGE_FID, 6), 32'h0000_0055);
        rchk("dbl_ctl_bcs", host.badr(MBCM_PAGE_BCS, 7), 32'h0000_01A8);
        rchk("dbl_ctl_ccf", host.badr(MBCM_PAGE_CCF, 7), 32'h0000_1234);
        rchk("dbl_ctl_fid", host.badr(MBCM_PAGE_FID, 7), 32'h0000_0000);
        host.wr(host.badr(MBCM_PAGE_BCS, 7), 32'h0000_0000);
        host.wr(host.badr(MBCM_PAGE_BCS, 7), 32'h0000_0002);
        rchk("dbl_ctl_ro", host.badr(MBCM_PAGE_BCS, 7), 32'h0000_01A8);
        host.wr(host.badr(MBCM_PAGE_BCS, 9), 32'h0000_01A8);
        rchk("dbl_odd", host.badr(MBCM_PAGE_BCS, 9), 32'h0000_0188);
        host.wr(host.badr(MBCM_PAGE_BCS, 11), 32'h0000_0020);
        rchk("dbl_rx", host.badr(MBCM_PAGE_BCS, 11), 32'h0000_0000);
        host.wr(host.badr(MBCM_PAGE_BCS, 58), 32'h0000_01A8);
        rchk("dbl_last", host.badr(MBCM_PAGE_BCS, 58), 32'h0000_0188);
        host.wr(host.badr(MBCM_PAGE_BCS, 59), 32'h0000_0100);
        rchk("beyond_map", host.badr(MBCM_PAGE_BCS, 59), 32'h0000_0000);
        host.cfg_buf(12, 32'h0000_0188, 32'h0000_0000, 32'h0000_0010);
        host.cfg_buf(14, 32'h0000_0108, 32'h0000_0000, 32'h0000_0020);
        rchk("dyn_tx_bcs", host.badr(MBCM_PAGE_BCS, 12), 32'h0000_0188);
    endtask : t_buffers

    task automatic t_normal();
        host.wr(MBCM_OFS_MCR, 32'h0000_0000);
        @(posedge mclk_i);
        #1;
        chk_states(32'h0000_0000, 32'h0000_0001);
        chk("fifo_applied", 32'h0000_0004, 32'(fifo_act));
        rchk("mcr_normal", MBCM_OFS_MCR, 32'h0000_0008);
        host.wr(MBCM_OFS_FSIZE, 32'h0000_0008);
        rchk("fsize_frozen", MBCM_OFS_FSIZE, 32'h0000_0004);
        host.wr(host.badr(MBCM_PAGE_FID, 12), 32'h0000_0033);
        rchk("dyn_fid", host.badr(MBCM_PAGE_FID, 12), 32'h0000_0033);
        host.wr(host.badr(MBCM_PAGE_FID, 14), 32'h0000_0044);
        rchk("static_fid", host.badr(MBCM_PAGE_FID, 14), 32'h0000_0020);
        host.wr(host.badr(MBCM_PAGE_CCF, 12), 32'h0000_00FF);
        rchk("ccf_frozen", host.badr(MBCM_PAGE_CCF, 12), 32'h0000_0000);
        host.wr(host.badr(MBCM_PAGE_BCS, 12), 32'h0000_0001);
        rchk("bcs_partial", host.badr(MBCM_PAGE_BCS, 12), 32'h0000_0189);
        host.wr(host.badr(MBCM_PAGE_BCS, 30), 32'h0000_0100);
        rchk("unconfigured", host.badr(MBCM_PAGE_BCS, 30), 32'h0000_0000);
        host.wr(host.badr(MBCM_PAGE_BCS, 6), 32'h0000_0000);
        rchk("dbl_frozen", host.badr(MBCM_PAGE_BCS, 6), 32'h0000_01A8);
        chk("fifo_kept", 32'h0000_0004, 32'(fifo_act));
    endtask : t_normal

    task automatic t_reenter();
        host.wr(MBCM_OFS_MCR, 32'h0000_0001);
        @(posedge mclk_i);
        #1;
        chk_states(32'h0000_0001, 32'h0000_0000);
        do_reset();
        rchk("bcs_rerst", host.badr(MBCM_PAGE_BCS, 6), 32'h0000_0000);
        rchk("fid_rerst", host.badr(MBCM_PAGE_FID, 12), 32'h0000_0000);
    endtask : t_reenter

    initial begin
        #3_000_000;
        fail_count++;
        end_sim();
    end

    initial begin
        resetn_i   = 1'b0;
        fail_count = 0;
        n_compared = 0;
        do_reset();
        t_reset_values();
        t_fifo_cfg();
        t_buffers();
        t_normal();
        t_reenter();
        end_sim();
    end
endmodule : testbench

// ==== hw/mbcm_top.sv ====
`timescale 1ns/1ps
module mbcm_top
    import mbcm_pkg::*;
#(
    parameter int unsigned NUM_BUF  = MBCM_NUM_BUF,
    parameter int unsigned FIFO_MAX = MBCM_FIFO_MAX
) (
    input  wire logic                  mclk_i,              // Controller clock, 10 MHz.
    input  wire logic                  resetn_i,            // Hard reset, active low.
    input  wire logic                  wb_cyc_i,            // Wishbone cycle.
    input  wire logic                  wb_stb_i,            // Wishbone strobe.
    input  wire logic                  wb_we_i,             // Wishbone write enable.
    input  wire logic [MBCM_ADR_W-1:0] wb_adr_i,            // Wishbone byte address.
    input  wire logic [3:0]            wb_sel_i,            // Wishbone byte lanes.
    input  wire logic [31:0]           wb_dat_i,            // Wishbone write data.
    output logic      [31:0]           wb_dat_o,            // Wishbone read data.
    output logic                       wb_ack_o,            // Wishbone acknowledge.
    output logic                       init_busy_o,         // Memory initialization running.
    output logic                       config_state_o,      // Configuration state.
    output logic                       normal_state_o,      // Normal operation.
    output logic      [MBCM_IDX_W-1:0] active_fifo_size_o   // FIFO length in effect.
);

    if (NUM_BUF < 2 || NUM_BUF > 64 || FIFO_MAX > NUM_BUF) begin : g_check
        $error("mbcm_top: NUM_BUF or FIFO_MAX out of range");
    end

    localparam logic [MBCM_IDX_W-1:0] LAST_BUF = MBCM_IDX_W'(NUM_BUF - 1);
    localparam logic [MBCM_IDX_W-1:0] FIFO_LIM = MBCM_IDX_W'(FIFO_MAX);

    mbcm_state_t           state;
    mbcm_state_t           next_state;
    logic [MBCM_IDX_W-1:0] init_idx;
    logic [MBCM_IDX_W-1:0] next_init_idx;
    logic                  cfg_req;
    logic                  next_cfg_req;
    logic [MBCM_IDX_W-1:0] fifo_size;
    logic [MBCM_IDX_W-1:0] next_fifo_size;
    logic [MBCM_IDX_W-1:0] act_fifo;
    logic [MBCM_IDX_W-1:0] next_act_fifo;
    logic                  ack;
    logic                  next_ack;
    logic [31:0]           rdata;
    logic [31:0]           next_rdata;

    mbcm_bcs_t             bcs [NUM_BUF];
    logic [MBCM_CCF_W-1:0] ccf [NUM_BUF];
    logic [MBCM_FID_W-1:0] fid [NUM_BUF];

    logic                  wr1_bcs;
    logic                  wr1_ccf;
    logic                  wr1_fid;
    logic [MBCM_IDX_W-1:0] wr1_idx;
    mbcm_bcs_t             wr1_bcs_val;
    logic [MBCM_CCF_W-1:0] wr1_ccf_val;
    logic [MBCM_FID_W-1:0] wr1_fid_val;
    logic                  wr2_bcs;
    logic                  wr2_ccf;
    logic                  wr2_fid;
    logic [MBCM_IDX_W-1:0] wr2_idx;

    logic                  req;
    logic                  in_page;
    logic [MBCM_IDX_W-1:0] idx;
    logic [31:0]           wmask;
    mbcm_bcs_t             cur;
    logic                  ctl_half;
    logic                  host_dbl;
    logic                  dyn_single_tx;

    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        logic [31:0] m;
        m = '0;
        for (int b = 0; b < 4; b++) begin
            m[8*b +: 8] = {8{sel[b]}};
        end
        return m;
    endfunction : lane_mask

    // Clears the fields that have no meaning for the buffer's type.
    function automatic mbcm_bcs_t unused_zero(input mbcm_bcs_t v);
        mbcm_bcs_t r;
        r = v;
        if (!r.dir) begin
            r.commit        = 1'b0; // RQ24
            r.transfer_type = 1'b0;
            r.buffer_type   = 1'b0; // RQ16
        end else begin
            r.data_update   = 1'b0; // RQ24
        end
        return r;
    endfunction : unused_zero

    assign req      = wb_cyc_i && wb_stb_i && !ack;
    assign idx      = wb_adr_i[7:2];
    assign in_page  = (idx <= LAST_BUF); // RQ19
    assign wmask    = lane_mask(wb_sel_i);
    assign cur      = in_page ? bcs[idx] : MBCM_BCS_RST;
    assign ctl_half = in_page && idx[0] && bcs[idx - 6'd1].buffer_type
                      && bcs[idx - 6'd1].dir; // RQ12
    assign host_dbl = in_page && cur.buffer_type && cur.dir;
    assign dyn_single_tx = in_page && cur.dir && !cur.buffer_type && cur.transfer_type
                           && !ctl_half && (idx >= act_fifo); // RQ21

    // Controller state sequence.
    always_comb begin
        next_state     = state;
        next_init_idx  = init_idx;
        next_cfg_req   = cfg_req;
        next_fifo_size = fifo_size;
        next_act_fifo  = act_fifo;
        unique case (state)
            MBCM_ST_INIT: begin
                next_init_idx = init_idx + 6'd1; // RQ3
                if (init_idx == LAST_BUF) begin
                    next_state = MBCM_ST_CONFIG; // RQ1
                end
            end
            MBCM_ST_CONFIG: begin
                if (!cfg_req) begin
                    next_state    = MBCM_ST_NORMAL; // RQ8
                    next_act_fifo = fifo_size; // RQ7
                end
            end
            MBCM_ST_NORMAL: begin
                if (cfg_req) begin
                    next_state = MBCM_ST_CONFIG; // RQ1
                end
            end
            default: begin
                next_state = MBCM_ST_INIT;
            end
        endcase
        if (req && wb_we_i && state != MBCM_ST_INIT) begin
            if (wb_adr_i == MBCM_OFS_MCR && wb_sel_i[0]) begin
                next_cfg_req = wb_dat_i[MBCM_MCR_CFG_REQ]; // RQ1
            end else if (wb_adr_i == MBCM_OFS_FSIZE && wb_sel_i[0]
                         && state == MBCM_ST_CONFIG
                         && wb_dat_i[7:MBCM_IDX_W] == '0
                         && wb_dat_i[MBCM_IDX_W-1:0] <= FIFO_LIM) begin
                next_fifo_size = wb_dat_i[MBCM_IDX_W-1:0]; // RQ11
            end
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state     <= MBCM_ST_INIT;
            init_idx  <= '0;
            cfg_req   <= MBCM_CFG_REQ_RST;
            fifo_size <= '0;
            act_fifo  <= '0;
        end else begin
            state     <= next_state;
            init_idx  <= next_init_idx;
            cfg_req   <= next_cfg_req;
            fifo_size <= next_fifo_size;
            act_fifo  <= next_act_fifo;
        end
    end

    // Buffer memory write ports; port two mirrors the host side of a double pair.
    always_comb begin
        mbcm_bcs_t nb;
        logic [31:0] m;
        nb          = MBCM_BCS_RST;
        m           = '0;
        wr1_bcs     = 1'b0;
        wr1_ccf     = 1'b0;
        wr1_fid     = 1'b0;
        wr1_idx     = idx;
        wr1_bcs_val = MBCM_BCS_RST;
        wr1_ccf_val = '0;
        wr1_fid_val = '0;
        wr2_bcs     = 1'b0;
        wr2_ccf     = 1'b0;
        wr2_fid     = 1'b0;
        wr2_idx     = idx + 6'd1;
        if (state == MBCM_ST_INIT) begin
            wr1_bcs = 1'b1; // RQ4
            wr1_ccf = 1'b1; // RQ4
            wr1_fid = 1'b1; // RQ2
            wr1_idx = init_idx;
        end else if (req && wb_we_i && in_page && !ctl_half) begin // RQ15
            if (state == MBCM_ST_CONFIG) begin
                m  = {20'h0_0000, ~MBCM_BCS_RO_MASK} & wmask;
                nb = mbcm_bcs_t'(12'((32'(cur) & ~m) | (wb_dat_i & m)));
                if (idx < fifo_size) begin
                    nb.dir = 1'b0; // RQ10
                end
                if (idx[0] || idx == LAST_BUF) begin
                    nb.buffer_type = 1'b0; // RQ13 RQ20
                end
                nb = unused_zero(nb); // RQ17
                if (wb_adr_i[11:8] == MBCM_PAGE_BCS) begin
                    wr1_bcs     = 1'b1;
                    wr1_bcs_val = nb;
                    if (nb.buffer_type && nb.dir) begin
                        wr2_bcs = 1'b1; // RQ14
                    end
                end else if (wb_adr_i[11:8] == MBCM_PAGE_CCF) begin
                    wr1_ccf     = 1'b1;
                    wr1_ccf_val = (ccf[idx] & ~wmask[MBCM_CCF_W-1:0])
                                  | (wb_dat_i[MBCM_CCF_W-1:0] & wmask[MBCM_CCF_W-1:0]);
                    wr2_ccf     = host_dbl; // RQ14
                end else if (wb_adr_i[11:8] == MBCM_PAGE_FID) begin
                    wr1_fid     = 1'b1;
                    wr1_fid_val = (fid[idx] & ~wmask[MBCM_FID_W-1:0])
                                  | (wb_dat_i[MBCM_FID_W-1:0] & wmask[MBCM_FID_W-1:0]);
                    wr2_fid     = host_dbl; // RQ14
                end
            end else begin
                if (wb_adr_i[11:8] == MBCM_PAGE_BCS) begin
                    m  = {20'h0_0000, MBCM_BCS_RT_MASK} & wmask; // RQ9 RQ23
                    nb = mbcm_bcs_t'(12'((32'(cur) & ~m) | (wb_dat_i & m)));
                    wr1_bcs     = 1'b1;
                    wr1_bcs_val = unused_zero(nb); // RQ22
                end else if (wb_adr_i[11:8] == MBCM_PAGE_FID && dyn_single_tx) begin
                    wr1_fid     = 1'b1; // RQ21
                    wr1_fid_val = (fid[idx] & ~wmask[MBCM_FID_W-1:0])
                                  | (wb_dat_i[MBCM_FID_W-1:0] & wmask[MBCM_FID_W-1:0]);
                end
            end
        end
    end

    // The mirror copies the new host-side value, with commit, lock and interrupt enable left clear.
    always_ff @(posedge mclk_i) begin
        if (wr1_bcs) begin
            bcs[wr1_idx] <= wr1_bcs_val;
        end
        if (wr1_ccf) begin
            ccf[wr1_idx] <= wr1_ccf_val;
        end
        if (wr1_fid) begin
            fid[wr1_idx] <= wr1_fid_val;
        end
        if (wr2_bcs) begin
            bcs[wr2_idx] <= mbcm_bcs_t'(wr1_bcs_val & ~MBCM_BCS_RT_MASK);
        end
        if (wr2_ccf) begin
            ccf[wr2_idx] <= wr1_ccf_val;
        end
        if (wr2_fid) begin
            fid[wr2_idx] <= wr1_fid_val;
        end
    end

    // Bus answer: one wait state, unmapped addresses read as zero.
    always_comb begin
        next_ack   = req;
        next_rdata = rdata;
        if (req && !wb_we_i) begin
            next_rdata = '0;
            if (wb_adr_i == MBCM_OFS_SIG) begin
                next_rdata = (state == MBCM_ST_INIT) ? '0 : {16'h0000, MBCM_SIG_VALUE}; // RQ5
            end else if (state == MBCM_ST_INIT) begin
                next_rdata = '0; // RQ5
            end else if (wb_adr_i == MBCM_OFS_MCR) begin
                next_rdata[MBCM_MCR_CFG_REQ] = cfg_req;
                next_rdata[MBCM_MCR_IN_CFG]  = (state == MBCM_ST_CONFIG);
                next_rdata[MBCM_MCR_NORMAL]  = (state == MBCM_ST_NORMAL);
            end else if (wb_adr_i == MBCM_OFS_FSIZE) begin
                next_rdata[MBCM_IDX_W-1:0] = fifo_size;
            end else if (in_page && wb_adr_i[1:0] == 2'b00) begin
                if (wb_adr_i[11:8] == MBCM_PAGE_BCS) begin
                    next_rdata[11:0] = unused_zero(cur); // RQ24
                end else if (wb_adr_i[11:8] == MBCM_PAGE_CCF) begin
                    next_rdata[MBCM_CCF_W-1:0] = ccf[idx];
                end else if (wb_adr_i[11:8] == MBCM_PAGE_FID && !ctl_half) begin
                    next_rdata[MBCM_FID_W-1:0] = fid[idx]; // RQ15
                end
            end
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack   <= 1'b0;
            rdata <= '0;
        end else begin
            ack   <= next_ack;
            rdata <= next_rdata;
        end
    end

    assign wb_ack_o           = ack;
    assign wb_dat_o           = rdata;
    assign init_busy_o        = (state == MBCM_ST_INIT);
    assign config_state_o     = (state == MBCM_ST_CONFIG);
    assign normal_state_o     = (state == MBCM_ST_NORMAL);
    assign active_fifo_size_o = act_fifo;

    property p_init_end;
        @(posedge mclk_i) disable iff (!resetn_i)
        (state == MBCM_ST_INIT && init_idx == '0) |-> ##[1:64] state == MBCM_ST_CONFIG;
    endproperty
    a_init_end: assert property (p_init_end) else $error("init did not end"); // RQ3

    property p_sig_hidden;
        @(posedge mclk_i) disable iff (!resetn_i)
        (req && !wb_we_i && state == MBCM_ST_INIT) |=> wb_ack_o && wb_dat_o == '0;
    endproperty
    a_sig_hidden: assert property (p_sig_hidden) else $error("data during init"); // RQ5

    property p_leave_cfg;
        @(posedge mclk_i) disable iff (!resetn_i)
        (state == MBCM_ST_CONFIG && !cfg_req) |=> state == MBCM_ST_NORMAL
            && act_fifo == $past(fifo_size);
    endproperty
    a_leave_cfg: assert property (p_leave_cfg) else $error("config exit wrong"); // RQ7

    property p_enter_cfg;
        @(posedge mclk_i) disable iff (!resetn_i)
        (state == MBCM_ST_NORMAL && cfg_req) |=> state == MBCM_ST_CONFIG;
    endproperty
    a_enter_cfg: assert property (p_enter_cfg) else $error("config entry missed"); // RQ1

    property p_fifo_frozen;
        @(posedge mclk_i) disable iff (!resetn_i)
        (state != MBCM_ST_CONFIG) |=> $stable(fifo_size) && fifo_size <= FIFO_LIM;
    endproperty
    a_fifo_frozen: assert property (p_fifo_frozen) else $error("fifo size changed"); // RQ11

    property p_act_fifo;
        @(posedge mclk_i) disable iff (!resetn_i)
        $changed(act_fifo) |-> $past(state) == MBCM_ST_CONFIG && state == MBCM_ST_NORMAL;
    endproperty
    a_act_fifo: assert property (p_act_fifo) else $error("fifo applied early"); // RQ7

    property p_mirror;
        @(posedge mclk_i) disable iff (!resetn_i)
        wr2_bcs |=> bcs[$past(wr2_idx)].buffer_type && bcs[$past(wr2_idx)].dir
            && !bcs[$past(wr2_idx)].lock;
    endproperty
    a_mirror: assert property (p_mirror) else $error("pair not mirrored"); // RQ14

    property p_normal_frozen;
        @(posedge mclk_i) disable iff (!resetn_i)
        (state == MBCM_ST_NORMAL && wr1_bcs)
            |=> (32'(bcs[$past(wr1_idx)]) & 32'(MBCM_BCS_CFG_MASK))
                == (32'($past(cur)) & 32'(MBCM_BCS_CFG_MASK));
    endproperty
    a_normal_frozen: assert property (p_normal_frozen) else $error("config changed"); // RQ25

    property p_ack_pulse;
        @(posedge mclk_i) disable iff (!resetn_i)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held"); // RQ5

    property p_ctl_refused;
        @(posedge mclk_i) disable iff (!resetn_i)
        (state != MBCM_ST_INIT && ctl_half) |-> !wr1_bcs && !wr1_ccf && !wr1_fid;
    endproperty
    a_ctl_refused: assert property (p_ctl_refused) else $error("pair half written"); // RQ15

    property p_fifo_rx;
        @(posedge mclk_i) disable iff (!resetn_i)
        (state == MBCM_ST_CONFIG && wr1_bcs && wr1_idx < fifo_size) |-> !wr1_bcs_val.dir;
    endproperty
    a_fifo_rx: assert property (p_fifo_rx) else $error("fifo buffer not rx"); // RQ10

    property p_odd_single;
        @(posedge mclk_i) disable iff (!resetn_i)
        (state == MBCM_ST_CONFIG && wr1_bcs && wr1_idx[0]) |-> !wr1_bcs_val.buffer_type;
    endproperty
    a_odd_single: assert property (p_odd_single) else $error("odd buffer double"); // RQ13

    property p_fid_dyn;
        @(posedge mclk_i) disable iff (!resetn_i)
        (state == MBCM_ST_NORMAL && wr1_fid) |-> dyn_single_tx;
    endproperty
    a_fid_dyn: assert property (p_fid_dyn) else $error("frame id changed"); // RQ21

endmodule : mbcm_top

// ==== include/mbcm_pkg.sv ====
// Overview of operation
// RQ1: Configuration state after reset or config request.
// RQ2: Reset leaves every buffer disabled receive, ID zero.
// RQ3: Initialization starts first clock edge after reset.
// RQ4: Initialization clears all buffer fields and filters.
// RQ5: During initialization only signature register answers; here every address is acked and reads zero, signature included.
// RQ6: Host configures, locks, fills, then unlocks buffers.
// RQ7: Clearing request leaves configuration; config then active.
// RQ8: Leaving configuration enters normal operation.
// RQ9: Unconfigured buffers stay disabled receive buffers.
// RQ10: FIFO starts at buffer zero, size register only.
// RQ11: FIFO size writable only in configuration, max 59.
// RQ12: Controller-side buffer is host-side buffer plus one.
// RQ13: Host-side buffer even, controller-side buffer odd.
// RQ14: Host-side configuration copied onto controller-side buffer.
// RQ15: Controller-side buffers read-only and never lockable.
// RQ16: Only transmit buffers may be double buffers.
// RQ17: Direction bit zero receive, one transmit.
// RQ18: No buffers inside FIFO or double pair.
// RQ19: Zero to 59 receive buffers allowed.
// RQ20: Up to 59 single or 29 double transmit.
// RQ21: Normal operation reconfigures only dynamic single transmit.
// RQ22: Normal operation freezes FIFO, types, filters, segments.
// RQ23: Configuration-writable fields read-only in normal operation.
// RQ24: Unused fields read zero and ignore writes.
// RQ25: Forbidden normal-operation writes silently ignored.
package mbcm_pkg;

    localparam int unsigned MBCM_ADR_W     = 12;
    localparam int unsigned MBCM_NUM_BUF   = 59;
    localparam int unsigned MBCM_FIFO_MAX  = 59;
    localparam int unsigned MBCM_IDX_W     = 6;

    localparam logic [11:0] MBCM_OFS_MCR   = 12'h000;
    localparam logic [11:0] MBCM_OFS_SIG   = 12'h004;
    localparam logic [11:0] MBCM_OFS_FSIZE = 12'h008;
    localparam logic [3:0]  MBCM_PAGE_BCS  = 4'h1;
    localparam logic [3:0]  MBCM_PAGE_CCF  = 4'h2;
    localparam logic [3:0]  MBCM_PAGE_FID  = 4'h3;

    localparam int unsigned MBCM_MCR_CFG_REQ  = 0;
    localparam int unsigned MBCM_MCR_IN_CFG   = 1;
    localparam int unsigned MBCM_MCR_INIT     = 2;
    localparam int unsigned MBCM_MCR_NORMAL   = 3;
    localparam logic        MBCM_CFG_REQ_RST  = 1'b1;

    localparam int unsigned MBCM_CCF_W     = 14;
    localparam int unsigned MBCM_FID_W     = 11;

    localparam logic [11:0] MBCM_BCS_CFG_MASK = 12'h9F8;
    localparam logic [11:0] MBCM_BCS_RT_MASK  = 12'h007;
    localparam logic [11:0] MBCM_BCS_RO_MASK  = 12'h600;

    // Signature shown once initialization is finished; value is arbitrary.
    localparam logic [15:0] MBCM_SIG_VALUE = 16'h5A3C;

    typedef enum logic [1:0] {
        MBCM_ST_INIT,
        MBCM_ST_CONFIG,
        MBCM_ST_NORMAL
    } mbcm_state_t;

    typedef struct packed {
        logic data_update;
        logic valid;
        logic full_flag;
        logic dir;
        logic transfer_type;
        logic cycle_filter_en;
        logic buffer_type;
        logic ch_b;
        logic ch_a;
        logic commit;
        logic lock;
        logic irq_en;
    } mbcm_bcs_t;

    localparam mbcm_bcs_t MBCM_BCS_RST = '0;

endpackage : mbcm_pkg
